// ==== verilog/swi_coproc_exec.sv ====
// trap and coprocessor instruction execute block with AXI4-Lite registers
// assumes condition evaluation is done elsewhere and given through the control register
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
module swi_coproc_exec (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output cpx_pkg::events_t events,
    output logic [31:0] pcValue,
    output logic [31:0] xferAddr,
    output logic [31:0] baseWbVal
);
    typedef struct packed {
        logic awHeld;
        logic [7:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic awRdy;
        logic wRdy;
        logic arRdy;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [31:0] instr;
        logic [31:0] pcAddr;
        logic [31:0] status;
        logic [31:0] base;
        logic [1:0] ctrl;
        logic [31:0] link;
        logic [31:0] saved;
        logic [31:0] newPc;
        logic [31:0] newBase;
        logic [31:0] xAddr;
        logic xWb;
        cpx_pkg::phase_t phase;
        logic [4:0] result;
        cpx_pkg::events_t ev;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    logic wrFire;
    logic execGo;
    logic xferGo;
    logic mapped;
    cpx_pkg::instr_class_t cls;
    logic [31:0] firstAddr;
    logic [31:0] newBase;
    logic [31:0] wrWord;

    // sort an instruction into the groups this block handles
    function automatic cpx_pkg::instr_class_t classify(input logic [31:0] i);
        logic [3:0] c;
        c = i[cpx_pkg::F_CLASS_HI:cpx_pkg::F_CLASS_LO];
        // data op seen through bit 4 and bits 24 to 27 only
        if (c == cpx_pkg::CLS_SWI) begin
            classify = cpx_pkg::CL_SWI;
        end else if (c == cpx_pkg::CLS_COP) begin
            classify = i[cpx_pkg::F_DOP_BIT] ? cpx_pkg::CL_COPROC_REG_TRANSFER : cpx_pkg::CL_CDP;
        end else if (c[3:1] == cpx_pkg::CLS_CLS) begin
            classify = cpx_pkg::CL_CPLS;
        end else begin
            classify = cpx_pkg::CL_NONE;
        end
    endfunction

    // merge write data into a register word under byte strobes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] m;
        m = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                m[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        merge = m;
    endfunction

    // address arithmetic for loads and stores
    cp_addr_unit addrUnit (
        .instr(st_r.wData),
        .baseVal(st_r.base),
        .pcAddr(st_r.pcAddr),
        .firstAddr(firstAddr),
        .newBase(newBase)
    );

    // decode of the pending bus write
    always_comb begin
        wrFire = st_r.awHeld && st_r.wHeld && !st_r.bvalid;
        execGo = wrFire && st_r.awAddr == cpx_pkg::OFF_INSTR && st_r.phase == cpx_pkg::PH_IDLE;
        xferGo = wrFire && st_r.awAddr == cpx_pkg::OFF_XFER && st_r.phase == cpx_pkg::PH_XFER;
        cls = classify(st_r.wData);
        wrWord = st_r.wData;
        case (st_r.awAddr)
            cpx_pkg::OFF_INSTR, cpx_pkg::OFF_PC, cpx_pkg::OFF_STATUS,
            cpx_pkg::OFF_BASE, cpx_pkg::OFF_CTRL, cpx_pkg::OFF_XFER: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // next state: bus channels, register writes and instruction execution
    always_comb begin
        st_nxt = st_r;
        st_nxt.ev = '0;
        if (s_axi_awvalid && st_r.awRdy) begin
            st_nxt.awHeld = 1'b1;
            st_nxt.awAddr = {s_axi_awaddr[7:2], 2'h0};
        end
        if (s_axi_wvalid && st_r.wRdy) begin
            st_nxt.wHeld = 1'b1;
            st_nxt.wData = s_axi_wdata;
            st_nxt.wStrb = s_axi_wstrb;
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        if (wrFire) begin
            st_nxt.awHeld = 1'b0;
            st_nxt.wHeld = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = mapped ? cpx_pkg::RESP_OKAY : cpx_pkg::RESP_SLVERR;
            case (st_r.awAddr)
                cpx_pkg::OFF_PC: st_nxt.pcAddr = merge(st_r.pcAddr, wrWord, st_r.wStrb);
                cpx_pkg::OFF_STATUS: st_nxt.status = merge(st_r.status, wrWord, st_r.wStrb);
                cpx_pkg::OFF_BASE: st_nxt.base = merge(st_r.base, wrWord, st_r.wStrb);
                cpx_pkg::OFF_CTRL: st_nxt.ctrl = wrWord[1:0];
                default: st_nxt.ctrl = st_r.ctrl;
            endcase
        end
        if (execGo) begin
            st_nxt.instr = wrWord;
            st_nxt.result = '0;
        end
        // no event when the condition fails; the word is still stored in instr and result cleared
        // undefined trap only on a passed condition
        if (execGo && st_r.ctrl[cpx_pkg::CTRL_COND]) begin
            case (cls)
                cpx_pkg::CL_SWI: begin
                    st_nxt.saved = st_r.status;
                    st_nxt.status = {st_r.status[31:cpx_pkg::MODE_W], cpx_pkg::MODE_SVC};
                    st_nxt.newPc = cpx_pkg::VEC_SWI;
                    st_nxt.link = st_r.pcAddr + cpx_pkg::WORD_BYTES;
                    st_nxt.ev.swiTrap = 1'b1;
                    st_nxt.ev.pcLoad = 1'b1;
                    st_nxt.result[0] = 1'b1;
                end
                cpx_pkg::CL_COPROC_REG_TRANSFER: begin
                    if (wrWord[cpx_pkg::F_CP_HI:cpx_pkg::F_CP_LO] == cpx_pkg::CP_CTRL_NUM) begin
                        st_nxt.ev.cp15Xfer = 1'b1;
                        st_nxt.result[1] = 1'b1;
                    end else begin
                        st_nxt.ev.undefTrap = 1'b1;
                        st_nxt.result[2] = 1'b1;
                    end
                end
                cpx_pkg::CL_CDP: begin
                    // completes at once, no result awaited
                    st_nxt.ev.undefTrap = 1'b1;
                    st_nxt.result[2] = 1'b1;
                end
                cpx_pkg::CL_CPLS: begin
                    // load and store trapped for emulation
                    st_nxt.ev.undefTrap = 1'b1;
                    st_nxt.ev.xferStrobe = 1'b1;
                    st_nxt.result[2] = 1'b1;
                    st_nxt.result[3] = 1'b1;
                    st_nxt.xAddr = firstAddr;
                    st_nxt.newBase = newBase;
                    // no write-back to the program counter
                    st_nxt.xWb = wrWord[cpx_pkg::F_WB]
                        && wrWord[cpx_pkg::F_RN_HI:cpx_pkg::F_RN_LO] != cpx_pkg::RN_PC;
                    st_nxt.phase = cpx_pkg::PH_XFER;
                end
                default: st_nxt.result = '0;
            endcase
        end
        // emulating coprocessor steps the transfer
        // late-abort bit ignored
        if (xferGo) begin
            if (wrWord[cpx_pkg::XF_ABORT]) begin
                // data trap with write-back, state otherwise kept
                st_nxt.ev.abortTrap = 1'b1;
                st_nxt.ev.baseWbEn = st_r.xWb;
                st_nxt.result[4] = 1'b1;
                st_nxt.phase = cpx_pkg::PH_IDLE;
            end else if (wrWord[cpx_pkg::XF_LAST]) begin
                st_nxt.ev.baseWbEn = st_r.xWb;
                st_nxt.phase = cpx_pkg::PH_IDLE;
            end else if (wrWord[cpx_pkg::XF_NEXT]) begin
                st_nxt.xAddr = st_r.xAddr + cpx_pkg::WORD_BYTES;
                st_nxt.ev.xferStrobe = 1'b1;
            end
            if (st_nxt.ev.baseWbEn) begin
                st_nxt.base = st_r.newBase;
            end
        end
        // read channel
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_r.arRdy) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = cpx_pkg::RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'h0})
                cpx_pkg::OFF_INSTR: st_nxt.rdata = st_r.instr;
                cpx_pkg::OFF_PC: st_nxt.rdata = st_r.pcAddr;
                cpx_pkg::OFF_STATUS: st_nxt.rdata = st_r.status;
                cpx_pkg::OFF_BASE: st_nxt.rdata = st_r.base;
                cpx_pkg::OFF_CTRL: st_nxt.rdata = {30'h0, st_r.ctrl};
                cpx_pkg::OFF_XFER: st_nxt.rdata = st_r.xAddr;
                cpx_pkg::OFF_RESULT: st_nxt.rdata = {26'h0, st_r.phase, st_r.result};
                cpx_pkg::OFF_LINK: st_nxt.rdata = st_r.link;
                cpx_pkg::OFF_SAVED: st_nxt.rdata = st_r.saved;
                cpx_pkg::OFF_NEWPC: st_nxt.rdata = st_r.newPc;
                cpx_pkg::OFF_NEWBASE: st_nxt.rdata = st_r.newBase;
                default: begin
                    st_nxt.rdata = cpx_pkg::RST_WORD;
                    st_nxt.rresp = cpx_pkg::RESP_SLVERR;
                end
            endcase
        end
        // ready flags held in flops
        st_nxt.awRdy = !st_nxt.awHeld && !st_nxt.bvalid;
        st_nxt.wRdy = !st_nxt.wHeld && !st_nxt.bvalid;
        st_nxt.arRdy = !st_nxt.rvalid;
    end

    // state register
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
            st_r.ctrl <= cpx_pkg::RST_CTRL;
            st_r.awRdy <= 1'b1;
            st_r.wRdy <= 1'b1;
            st_r.arRdy <= 1'b1;
            st_r.phase <= cpx_pkg::PH_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state flops
    assign s_axi_awready = st_r.awRdy;
    assign s_axi_wready = st_r.wRdy;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = st_r.arRdy;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;
    assign events = st_r.ev;
    assign pcValue = st_r.newPc;
    assign xferAddr = st_r.xAddr;
    assign baseWbVal = st_r.base;

    // checks on the execute behaviour
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    logic passGo;
    assign passGo = execGo && st_r.ctrl[cpx_pkg::CTRL_COND];
    // fields of the word now being executed, shared by the checks below
    logic lsGo;
    logic [3:0] cpNum;
    logic [3:0] rnNum;
    logic [31:0] wordOff;
    assign lsGo = passGo && cls == cpx_pkg::CL_CPLS;
    assign cpNum = st_r.wData[cpx_pkg::F_CP_HI:cpx_pkg::F_CP_LO];
    assign rnNum = st_r.wData[cpx_pkg::F_RN_HI:cpx_pkg::F_RN_LO];
    assign wordOff = {22'h0, st_r.wData[7:0], 2'h0};

    sequence s_swiEntry;
        events.swiTrap && events.pcLoad && pcValue == cpx_pkg::VEC_SWI;
    endsequence
    sequence s_svcSaved;
        st_r.status[4:0] == cpx_pkg::MODE_SVC && st_r.saved == $past(st_r.status);
    endsequence
    sequence s_lsStart;
        events.undefTrap && events.xferStrobe && st_r.phase == cpx_pkg::PH_XFER;
    endsequence

    chk_cond_gate: assert property (execGo && !st_r.ctrl[0] |=> events == '0)
        else $error("failed condition still acted");
    chk_swi_entry: assert property (
        passGo && cls == cpx_pkg::CL_SWI |=> s_swiEntry and s_svcSaved)
        else $error("software trap entry wrong");
    chk_swi_link: assert property (
        passGo && cls == cpx_pkg::CL_SWI |=> st_r.link == $past(st_r.pcAddr) + 32'h4)
        else $error("link value wrong");
    chk_cdp_trap: assert property (
        passGo && cls == cpx_pkg::CL_CDP |=> events.undefTrap ##1 !events.undefTrap)
        else $error("data op not trapped");
    chk_cp15_accept: assert property (
        passGo && cls == cpx_pkg::CL_COPROC_REG_TRANSFER && cpNum == cpx_pkg::CP_CTRL_NUM
        |=> events.cp15Xfer && !events.undefTrap)
        else $error("control coprocessor transfer refused");
    chk_coproc_reg_transfer_other: assert property (
        passGo && cls == cpx_pkg::CL_COPROC_REG_TRANSFER && cpNum != cpx_pkg::CP_CTRL_NUM
        |=> events.undefTrap && !events.cp15Xfer)
        else $error("foreign register transfer not trapped");
    chk_ls_start: assert property (lsGo |=> s_lsStart)
        else $error("load or store did not start a transfer");
    chk_offset_up: assert property (
        lsGo && st_r.wData[cpx_pkg::F_PRE] && st_r.wData[cpx_pkg::F_UP] && rnNum != cpx_pkg::RN_PC
        |=> xferAddr == $past(st_r.base) + $past(wordOff))
        else $error("pre-indexed up address wrong");
    chk_post_first: assert property (
        lsGo && !st_r.wData[cpx_pkg::F_PRE] && rnNum != cpx_pkg::RN_PC
        |=> xferAddr == $past(st_r.base))
        else $error("post-indexed first address moved");
    chk_pc_base: assert property (
        lsGo && st_r.wData[cpx_pkg::F_PRE] && st_r.wData[cpx_pkg::F_UP] && rnNum == cpx_pkg::RN_PC
        |=> xferAddr == $past(st_r.pcAddr) + cpx_pkg::PC_AHEAD + $past(wordOff))
        else $error("program counter base not ahead by eight");
    chk_word_step: assert property (
        xferGo && st_r.wData[2:0] == 3'h1
        |=> xferAddr == $past(xferAddr) + 32'h4 && events.xferStrobe)
        else $error("transfer address not stepped by a word");
    chk_wb_gate: assert property (
        xferGo && st_r.wData[2:1] == 2'h2 |=> events.baseWbEn == $past(st_r.xWb))
        else $error("write-back not gated by the write bit");
    chk_abort_wb: assert property (
        xferGo && st_r.wData[1] && st_r.xWb
        |=> events.abortTrap && events.baseWbEn && baseWbVal == $past(st_r.newBase))
        else $error("abort lost the base write-back");
endmodule

// ==== verilog/cpx_pkg.sv ====
// constants and carrier types for the trap and coprocessor execute block
// assumes a 32-bit core on one 20 MHz clock, registers reached over AXI4-Lite
// Functional notes
// - trap and coprocessor instructions act only when the condition passes
// - software trap enters supervisor, saves status, jumps to vector 0x08
// - supervisor link gets the address of the word after the trap
// - low 24 bits of a software trap are a free comment field
// - only coprocessor 15 exists and it accepts only register transfers
// - data ops, loads, stores and non-15 coprocessors raise the undefined trap
// - data op decode looks only at bit 4 and bits 24 to 27
// - data ops are never waited on and return no result
// - core makes every address, coprocessor handles data and word count
// - offset is 8-bit immediate times four, added if up, else subtracted
// - pre bit chooses offset before or after use, write bit gates write-back
// - first word at adjusted base, each later word four bytes higher
// - two low address bits pass through unchanged
// - base of program counter reads instruction address plus 8, no write-back
// - abort takes data trap, still writes base back, keeps other state
// - late-abort configuration bit changes nothing for these transfers
package cpx_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_INSTR = 8'h00;
    localparam logic [7:0] OFF_PC = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_BASE = 8'h0C;
    localparam logic [7:0] OFF_CTRL = 8'h10;
    localparam logic [7:0] OFF_XFER = 8'h14;
    localparam logic [7:0] OFF_RESULT = 8'h18;
    localparam logic [7:0] OFF_LINK = 8'h1C;
    localparam logic [7:0] OFF_SAVED = 8'h20;
    localparam logic [7:0] OFF_NEWPC = 8'h24;
    localparam logic [7:0] OFF_NEWBASE = 8'h28;
    // control and transfer command bits
    localparam int CTRL_COND = 0;
    localparam int CTRL_LATEABT = 1;
    localparam int XF_NEXT = 0;
    localparam int XF_ABORT = 1;
    localparam int XF_LAST = 2;
    // instruction fields
    localparam int F_CLASS_HI = 27;
    localparam int F_CLASS_LO = 24;
    localparam int F_DOP_BIT = 4;
    localparam int F_PRE = 24;
    localparam int F_UP = 23;
    localparam int F_WB = 21;
    localparam int F_RN_HI = 19;
    localparam int F_RN_LO = 16;
    localparam int F_CP_HI = 11;
    localparam int F_CP_LO = 8;
    localparam logic [3:0] CLS_SWI = 4'hF;
    localparam logic [3:0] CLS_COP = 4'hE;
    localparam logic [2:0] CLS_CLS = 3'h6;
    localparam logic [3:0] CP_CTRL_NUM = 4'hF;
    localparam logic [3:0] RN_PC = 4'hF;
    // status mode field and vector
    localparam int MODE_W = 5;
    localparam logic [4:0] MODE_SVC = 5'h13;
    localparam logic [31:0] VEC_SWI = 32'h0000_0008;
    localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
    localparam logic [31:0] PC_AHEAD = 32'h0000_0008;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [1:0] RST_CTRL = 2'h1;

    typedef enum logic [2:0] {CL_NONE, CL_SWI, CL_CDP, CL_COPROC_REG_TRANSFER, CL_CPLS} instr_class_t;
    typedef enum logic {PH_IDLE, PH_XFER} phase_t;

    // event pulses towards the rest of the core
    typedef struct packed {
        logic swiTrap;
        logic undefTrap;
        logic abortTrap;
        logic cp15Xfer;
        logic pcLoad;
        logic xferStrobe;
        logic baseWbEn;
    } events_t;
endpackage

// ==== verilog/cp_addr_unit.sv ====
// address arithmetic for coprocessor loads and stores
// assumes instruction fields and register values are stable in the same cycle
module cp_addr_unit (
    input wire logic [31:0] instr,
    input wire logic [31:0] baseVal,
    input wire logic [31:0] pcAddr,
    output logic [31:0] firstAddr,
    output logic [31:0] newBase
);
    logic [31:0] baseUsed;
    logic [31:0] offset;
    // offset, base select and pre or post choice
    always_comb begin
        baseUsed = (instr[cpx_pkg::F_RN_HI:cpx_pkg::F_RN_LO] == cpx_pkg::RN_PC)
            ? pcAddr + cpx_pkg::PC_AHEAD : baseVal;
        offset = {22'h0, instr[7:0], 2'h0};
        newBase = instr[cpx_pkg::F_UP] ? baseUsed + offset : baseUsed - offset;
        firstAddr = instr[cpx_pkg::F_PRE] ? newBase : baseUsed;
    end
endmodule

// ==== sim/coproc_emul.sv ====
// emulated coprocessor that stands behind the undefined trap handler
// assumes the bench hands it the instruction word now being executed
module coproc_emul #(
    parameter logic [15:0] EMUL_MASK = 16'h0006
) (
    input wire logic [31:0] instr,
    output logic accept,
    output logic [2:0] words
);
    timeunit 1ns;
    timeprecision 1ns;
    assign accept = EMUL_MASK[instr[11:8]];
    assign words = !accept ? 3'h0 : (instr[22] ? 3'h4 : 3'h1);
endmodule

// ==== sim/test_swi_coproc_exec.sv ====
// self-checking bench for the trap and coprocessor execute block
// assumes a single 20 MHz clock and the bench as the only register master
module test_swi_coproc_exec;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [31:0] instr;
        logic [31:0] base;
        logic [31:0] first;
        logic [31:0] endBase;
        logic abt;
        logic late;
    } ls_t;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] awAddr = 8'h00;
    logic [7:0] arAddr = 8'h00;
    logic [31:0] wData = 32'h0;
    logic awValid = 1'b0;
    logic wValid = 1'b0;
    logic bReady = 1'b0;
    logic arValid = 1'b0;
    logic rReady = 1'b0;
    logic awReady, wReady, bValid, arReady, rValid, accept;
    logic [1:0] bResp, rResp;
    logic [2:0] words;
    logic [31:0] rData, pcValue, xferAddr, baseWbVal, rdVal;
    logic [31:0] curInstr = 32'h0;
    cpx_pkg::events_t events, evCap;
    int err_count = 0;
    int checked = 0;
    logic [31:0] trapCode [2] = '{32'hEF12_3456, 32'hEFAB_CDEF};
    // top nibble: condition pass, then expected trap, undefined, control transfer
    logic [35:0] clsTab [7] = '{{4'h0, 32'hEF00_0000}, {4'h0, 32'hEE00_0100},
        {4'hA, 32'hEE00_0100}, {4'hA, 32'hEEFF_FFEF}, {4'h9, 32'hEE10_0F10},
        {4'hA, 32'hEE10_0310}, {4'h8, 32'hE000_0000}};
    ls_t lsTab [5] = '{
        '{32'hEDB2_0103, 32'h0000_1000, 32'h0000_100C, 32'h0000_100C, 1'b0, 1'b0},
        '{32'hEC62_0204, 32'h0000_2002, 32'h0000_2002, 32'h0000_1FF2, 1'b0, 1'b0},
        '{32'hED13_0102, 32'h0000_3000, 32'h0000_2FF8, 32'h0000_3000, 1'b1, 1'b0},
        '{32'hED8F_0101, 32'h0000_5000, 32'h0000_040C, 32'h0000_5000, 1'b0, 1'b0},
        '{32'hEDB2_0103, 32'h0000_1000, 32'h0000_100C, 32'h0000_100C, 1'b1, 1'b1}};

    always #25 core_clk = ~core_clk;

    swi_coproc_exec uut (
        .core_clk(core_clk), .reset_n(reset_n),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
        .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady), .events(events),
        .pcValue(pcValue), .xferAddr(xferAddr), .baseWbVal(baseWbVal)
    );

    coproc_emul #(.EMUL_MASK(16'h0006)) emul (.instr(curInstr), .accept(accept), .words(words));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one write; the events of the answering cycle are kept in evCap
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge core_clk);
        awAddr <= a;
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awValid && awReady) awValid <= 1'b0;
            if (wValid && wReady) wValid <= 1'b0;
        end while (!bValid);
        bReady <= 1'b0;
        evCap = events;
        chk("bresp", {30'h0, bResp}, {30'h0, er});
    endtask

    // one read; data land in rdVal
    task automatic rd(input logic [7:0] a, input logic [1:0] er);
        @(posedge core_clk);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arValid && arReady) arValid <= 1'b0;
        end while (!rValid);
        rReady <= 1'b0;
        rdVal = rData;
        chk("rresp", {30'h0, rResp}, {30'h0, er});
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rd(a, cpx_pkg::RESP_OKAY);
        chk($sformatf("reg %h", a), rdVal, e);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        give_verdict();
    end

    initial begin
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        // reset values and an unmapped place
        rc(cpx_pkg::OFF_CTRL, {30'h0, cpx_pkg::RST_CTRL});
        rc(cpx_pkg::OFF_NEWPC, 32'h0);
        wr(8'h40, 32'h1, cpx_pkg::RESP_SLVERR);
        rd(8'h40, cpx_pkg::RESP_SLVERR);
        chk("unmapped data", rdVal, 32'h0);
        // software trap with two different comment fields
        foreach (trapCode[i]) begin
            wr(cpx_pkg::OFF_PC, 32'h0000_0100, cpx_pkg::RESP_OKAY);
            wr(cpx_pkg::OFF_STATUS, 32'h0000_0010, cpx_pkg::RESP_OKAY);
            wr(cpx_pkg::OFF_INSTR, trapCode[i], cpx_pkg::RESP_OKAY);
            chk("trap event", 32'(evCap.swiTrap), 32'h1);
            chk("trap load", 32'(evCap.pcLoad), 32'h1);
            chk("trap pc", pcValue, cpx_pkg::VEC_SWI);
            rc(cpx_pkg::OFF_LINK, 32'h0000_0104);
            rc(cpx_pkg::OFF_SAVED, 32'h0000_0010);
            rd(cpx_pkg::OFF_STATUS, cpx_pkg::RESP_OKAY);
            chk("mode", 32'(rdVal[4:0]), 32'(cpx_pkg::MODE_SVC));
        end
        // condition gating and class decode
        foreach (clsTab[i]) begin
            wr(cpx_pkg::OFF_CTRL, {31'h0, clsTab[i][35]}, cpx_pkg::RESP_OKAY);
            wr(cpx_pkg::OFF_INSTR, clsTab[i][31:0], cpx_pkg::RESP_OKAY);
            chk("class events", {29'h0, evCap.swiTrap, evCap.undefTrap, evCap.cp15Xfer},
                {29'h0, clsTab[i][34:32]});
        end
        // loads and stores walked with the emulated coprocessor
        foreach (lsTab[i]) begin
            wr(cpx_pkg::OFF_CTRL, {30'h0, lsTab[i].late, 1'b1}, cpx_pkg::RESP_OKAY);
            wr(cpx_pkg::OFF_PC, 32'h0000_0400, cpx_pkg::RESP_OKAY);
            wr(cpx_pkg::OFF_BASE, lsTab[i].base, cpx_pkg::RESP_OKAY);
            curInstr = lsTab[i].instr;
            wr(cpx_pkg::OFF_INSTR, lsTab[i].instr, cpx_pkg::RESP_OKAY);
            chk("ls events", {30'h0, evCap.undefTrap, evCap.xferStrobe}, 32'h3);
            chk("accept", 32'(accept), 32'h1);
            rc(cpx_pkg::OFF_XFER, lsTab[i].first);
            chk("xfer port", xferAddr, lsTab[i].first);
            for (int k = 1; k < int'(words); k++) begin
                wr(cpx_pkg::OFF_XFER, 32'h1, cpx_pkg::RESP_OKAY);
                chk("step strobe", 32'(evCap.xferStrobe), 32'h1);
                rc(cpx_pkg::OFF_XFER, lsTab[i].first + 32'(k) * cpx_pkg::WORD_BYTES);
            end
            wr(cpx_pkg::OFF_XFER, lsTab[i].abt ? 32'h2 : 32'h4, cpx_pkg::RESP_OKAY);
            chk("end events", {30'h0, evCap.abortTrap, evCap.baseWbEn}, {30'h0, lsTab[i].abt,
                lsTab[i].instr[21] && lsTab[i].instr[19:16] != 4'hF});
            rc(cpx_pkg::OFF_BASE, lsTab[i].endBase);
            chk("base port", baseWbVal, lsTab[i].endBase);
            rc(cpx_pkg::OFF_PC, 32'h0000_0400);
        end
        give_verdict();
    end
endmodule
